// File: t2_map.svh
// address map, reset values and divider counts of the third timer
`ifndef T2_MAP_SVH
`define T2_MAP_SVH
`define T2_ADDR_CON    8'hc8
`define T2_ADDR_MOD    8'hc9
`define T2_ADDR_RLD_LO 8'hca
`define T2_ADDR_RLD_HI 8'hcb
`define T2_ADDR_CNT_LO 8'hcc
`define T2_ADDR_CNT_HI 8'hcd
`define T2_CON_RESET   8'h00
`define T2_MOD_RESET   2'h0
`define T2_WORD_RESET  16'h0000
`define T2_WORD_MAX    16'hffff
`define T2_RDATA_NONE  8'h00
`define T2_MC_DIV      12
`define T2_ST_DIV      2
`endif

// File: t2_pkg.sv
// types shared by the third timer modules
package t2_pkg;
    // bit order is the control register layout, msb first
    typedef struct packed {
        logic ovf_flag;
        logic ext_flag;
        logic rx_sel;
        logic tx_sel;
        logic trig_en;
        logic run;
        logic src_sel;
        logic cap_sel;
    } t2_ctrl_t;

    typedef struct packed {
        logic clkout_en;
        logic updown_en;
    } t2_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } t2_sfr_req_t;

    typedef struct packed {
        logic rx_sel;
        logic tx_sel;
        logic rx_tick;
        logic tx_tick;
    } t2_baud_t;
endpackage : t2_pkg

// File: t2_fall_sync.sv
// pin synchroniser with falling edge detect
`timescale 1ns/1ns
module t2_fall_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      fall_o
);
    logic meta_q, sync_q, prev_q;
    logic meta_d, sync_d, prev_d;

    always_comb begin
        meta_d  = pin_i;
        sync_d  = meta_q;
        prev_d  = sync_q;
        level_o = sync_q;
        // compare consecutive synchronised samples only
        fall_o  = prev_q & ~sync_q; // RULE21
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= meta_d; // RULE21
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end
endmodule : t2_fall_sync

// File: t2_timer.sv
// third timer: capture, auto-reload, up/down and baud generator
`timescale 1ns/1ns
`include "t2_map.svh"
// Function
// (RULE1) overflow flag set on overflow, software clears, never set in baud mode
// (RULE2) external flag set when trigger edge causes capture or reload with enable
// (RULE3) external flag raises no interrupt in up/down mode
// (RULE4) set flags give a pending interrupt when the timer interrupt is enabled
// (RULE5) receive select sends overflow pulses as serial receive clock
// (RULE6) transmit select sends overflow pulses as serial transmit clock
// (RULE7) trigger enable lets trigger edges capture or reload, not in baud mode
// (RULE8) counter advances only while run bit is set
// (RULE9) source select picks machine cycles or falling count pin edges
// (RULE10) capture select: capture on trigger edge, else reload on overflow/trigger
// (RULE11) any serial clock select forces reload on overflow
// (RULE12) baud mode rollover loads counter from the reload registers
// (RULE13) internal tick is osc/2 in baud mode, osc/12 otherwise
// (RULE14) serial bit rate is osc over 32 times (65536 minus reload)
// (RULE15) baud mode trigger edge sets external flag without reload
// (RULE16) software leaves counter alone in baud mode, stops timer before access
// (RULE17) software sets run bit separately after configuring
// (RULE18) mode register: bit 0 up/down enable, bit 1 clock-out enable; the code stores bit 1 but drives no clock output
// (RULE19) trigger pin is capture, reload or direction input by mode
// (RULE20) capture copies counter into reload registers without stopping count
// (RULE21) count and trigger pins synchronised, falling edge from consecutive samples
module t2_timer
    import t2_pkg::*;
#(
    parameter int MC_DIV = `T2_MC_DIV
) (
    input  wire logic         CLK_SYS_I,
    input  wire logic         RST_I,
    input  wire t2_sfr_req_t  SFR_REQ_I,
    output logic [7:0]        SFR_RDATA_O,
    input  wire logic         COUNT_PIN_I,
    input  wire logic         TRIGGER_PIN_I,
    input  wire logic         TIMER_IRQ_EN_I,
    output logic              IRQ_O,
    output t2_baud_t          BAUD_O
);
    t2_ctrl_t    ctl_q, ctl_d;
    t2_mode_t    mode_q, mode_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] rld_q, rld_d;
    logic [3:0]  pre_q, pre_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        irq_q, irq_d;
    t2_baud_t    baud_q, baud_d;

    logic cnt_fall, trig_lvl, trig_fall;
    logic baud, tick_mc, tick_st, tick, dir_down, ovf, undf;
    logic trig, cap_evt, trig_rld, exf_set, tf_set, con_wr, cnt_wr;

    t2_fall_sync u_count_sync (
        .clk_i   (CLK_SYS_I),
        .rst_i   (RST_I),
        .pin_i   (COUNT_PIN_I),
        .level_o (),
        .fall_o  (cnt_fall)
    );

    t2_fall_sync u_trig_sync (
        .clk_i   (CLK_SYS_I),
        .rst_i   (RST_I),
        .pin_i   (TRIGGER_PIN_I),
        .level_o (trig_lvl),
        .fall_o  (trig_fall)
    );

    always_comb begin
        // prescaler for machine cycle and state time
        pre_d   = (pre_q == 4'(MC_DIV - 1)) ? 4'h0 : pre_q + 4'h1;
        tick_mc = (pre_q == 4'(MC_DIV - 1));
        tick_st = ((pre_q % 4'(`T2_ST_DIV)) == 4'(`T2_ST_DIV - 1)); // RULE13
        baud    = ctl_q.rx_sel | ctl_q.tx_sel;
        tick    = ctl_q.run & (ctl_q.src_sel ? cnt_fall              // RULE8 RULE9
                                             : (baud ? tick_st : tick_mc)); // RULE13
        // trigger level steers direction in up/down reload mode
        dir_down = mode_q.updown_en & ~baud & ~ctl_q.cap_sel & ~trig_lvl; // RULE19
        ovf      = tick & ~dir_down & (cnt_q == `T2_WORD_MAX);
        undf     = tick & dir_down & (cnt_q == rld_q);
        trig     = ctl_q.trig_en & trig_fall; // RULE7
        cap_evt  = trig & ctl_q.cap_sel & ~baud; // RULE10
        trig_rld = trig & ~ctl_q.cap_sel & ~baud & ~mode_q.updown_en; // RULE10
        // up/down mode uses the pin level for direction, so its edge raises no flag
        exf_set  = trig & (baud | ctl_q.cap_sel | ~mode_q.updown_en); // RULE2 RULE15
        tf_set   = (ovf | undf) & ~baud; // RULE1
        con_wr   = SFR_REQ_I.wr & (SFR_REQ_I.addr == `T2_ADDR_CON);
        cnt_wr   = SFR_REQ_I.wr & ((SFR_REQ_I.addr == `T2_ADDR_CNT_LO)
                                 | (SFR_REQ_I.addr == `T2_ADDR_CNT_HI));
    end

    always_comb begin
        cnt_d = cnt_q;
        if (trig_rld) begin
            cnt_d = rld_q; // RULE10
        end else if (ovf && (baud || !ctl_q.cap_sel)) begin
            cnt_d = rld_q; // RULE11 RULE12 RULE14
        end else if (undf) begin
            cnt_d = `T2_WORD_MAX;
        end else if (tick) begin
            cnt_d = dir_down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end
        rld_d = rld_q;
        if (cap_evt) begin
            rld_d = cnt_q; // RULE20
        end
        ctl_d  = ctl_q;
        mode_d = mode_q;
        // software writes win over counting; it is expected to stop the timer first
        if (SFR_REQ_I.wr) begin
            if (SFR_REQ_I.addr == `T2_ADDR_CON) begin
                ctl_d = t2_ctrl_t'(SFR_REQ_I.wdata);
            end else if (SFR_REQ_I.addr == `T2_ADDR_MOD) begin
                mode_d = t2_mode_t'(SFR_REQ_I.wdata[1:0]); // RULE18
            end else if (SFR_REQ_I.addr == `T2_ADDR_RLD_LO) begin
                rld_d[7:0] = SFR_REQ_I.wdata;
            end else if (SFR_REQ_I.addr == `T2_ADDR_RLD_HI) begin
                rld_d[15:8] = SFR_REQ_I.wdata;
            end else if (SFR_REQ_I.addr == `T2_ADDR_CNT_LO) begin
                cnt_d[7:0] = SFR_REQ_I.wdata;
            end else if (SFR_REQ_I.addr == `T2_ADDR_CNT_HI) begin
                cnt_d[15:8] = SFR_REQ_I.wdata;
            end
        end
        // hardware set beats a software clear in the same cycle
        if (tf_set) begin
            ctl_d.ovf_flag = 1'b1; // RULE1
        end
        if (exf_set) begin
            ctl_d.ext_flag = 1'b1; // RULE2
        end
        irq_d = TIMER_IRQ_EN_I & (ctl_q.ovf_flag                      // RULE4
                                  | (ctl_q.ext_flag & ~mode_q.updown_en)); // RULE3
        baud_d.rx_sel  = ctl_q.rx_sel;
        baud_d.tx_sel  = ctl_q.tx_sel;
        baud_d.rx_tick = ovf & ctl_q.rx_sel; // RULE5
        baud_d.tx_tick = ovf & ctl_q.tx_sel; // RULE6
        rdata_d = rdata_q;
        if (SFR_REQ_I.rd) begin
            if (SFR_REQ_I.addr == `T2_ADDR_CON) begin
                rdata_d = ctl_q;
            end else if (SFR_REQ_I.addr == `T2_ADDR_MOD) begin
                rdata_d = {6'h00, mode_q};
            end else if (SFR_REQ_I.addr == `T2_ADDR_RLD_LO) begin
                rdata_d = rld_q[7:0];
            end else if (SFR_REQ_I.addr == `T2_ADDR_RLD_HI) begin
                rdata_d = rld_q[15:8];
            end else if (SFR_REQ_I.addr == `T2_ADDR_CNT_LO) begin
                rdata_d = cnt_q[7:0];
            end else if (SFR_REQ_I.addr == `T2_ADDR_CNT_HI) begin
                rdata_d = cnt_q[15:8];
            end else begin
                rdata_d = `T2_RDATA_NONE;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ctl_q   <= t2_ctrl_t'(`T2_CON_RESET);
            mode_q  <= t2_mode_t'(`T2_MOD_RESET);
            cnt_q   <= `T2_WORD_RESET;
            rld_q   <= `T2_WORD_RESET;
            pre_q   <= 4'h0;
            rdata_q <= `T2_RDATA_NONE;
            irq_q   <= 1'b0;
            baud_q  <= '0;
        end else begin
            ctl_q   <= ctl_d;
            mode_q  <= mode_d;
            cnt_q   <= cnt_d;
            rld_q   <= rld_d;
            pre_q   <= pre_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
            baud_q  <= baud_d;
        end
    end

    assign SFR_RDATA_O = rdata_q;
    assign IRQ_O       = irq_q;
    assign BAUD_O      = baud_q;

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence s_baud_ovf;
        ovf && baud && !cnt_wr;
    endsequence

    ovf_flag_set_a: assert property (tf_set |=> ctl_q.ovf_flag) // RULE1
        else $error("overflow flag not set");
    ovf_flag_baud_a: assert property ((baud && !con_wr) |=> !$rose(ctl_q.ovf_flag)) // RULE1
        else $error("overflow flag set in baud mode");
    ext_flag_set_a: assert property (exf_set |=> ctl_q.ext_flag) // RULE2
        else $error("external flag not set");
    irq_source_a: assert property (IRQ_O |-> $past(ctl_q.ovf_flag) // RULE3
        || ($past(ctl_q.ext_flag) && !$past(mode_q.updown_en)))
        else $error("interrupt without a valid source");
    irq_raise_a: assert property ((TIMER_IRQ_EN_I && ctl_q.ovf_flag) |=> IRQ_O) // RULE4
        else $error("pending overflow not presented");
    rx_tick_a: assert property ((ovf && ctl_q.rx_sel) |=> BAUD_O.rx_tick) // RULE5
        else $error("receive tick missing");
    tx_tick_a: assert property ((ovf && ctl_q.tx_sel) |=> BAUD_O.tx_tick) // RULE6
        else $error("transmit tick missing");
    run_stop_a: assert property ((!ctl_q.run && !cnt_wr && !trig_rld) |=> $stable(cnt_q)) // RULE8
        else $error("counter moved while stopped");
    // a control write may stop the timer, so it opens no window
    sequence s_state_tick;
        (baud && !ctl_q.src_sel && ctl_q.run && tick && !con_wr) ##1 !con_wr;
    endsequence
    state_tick_a: assert property (s_state_tick |-> !tick ##1 tick) // RULE13
        else $error("baud tick not every second cycle");
    baud_reload_a: assert property (s_baud_ovf |=> cnt_q == $past(rld_q)) // RULE12
        else $error("baud rollover did not reload");
    trig_baud_a: assert property ((trig && baud && !cnt_wr && !tick) // RULE15
        |=> ctl_q.ext_flag && $stable(cnt_q))
        else $error("baud trigger reloaded the counter");
    capture_a: assert property ((cap_evt && !SFR_REQ_I.wr) |=> rld_q == $past(cnt_q)) // RULE20
        else $error("capture lost the counter value");
endmodule : t2_timer

// File: t2_far_model.sv
// pin driver and serial clock listener facing the third timer
`timescale 1ns/1ns
module t2_far_model
    import t2_pkg::*;
(
    input  wire logic     clk_i,
    input  wire t2_baud_t baud_i,
    output logic          count_pin_o,
    output logic          trig_pin_o
);
    int tx_cnt = 0;
    int rx_cnt = 0;
    // port pins idle high through pull-ups
    initial begin
        count_pin_o = 1'b1;
        trig_pin_o  = 1'b1;
    end
    // serial side just counts bit clock pulses
    always @(posedge clk_i) begin
        if (baud_i.tx_tick === 1'b1) tx_cnt <= tx_cnt + 1;
        if (baud_i.rx_tick === 1'b1) rx_cnt <= rx_cnt + 1;
    end
    // low and high for 3 cycles each so the synchroniser sees every edge
    task pulse(input logic trig);
        @(negedge clk_i);
        if (trig) trig_pin_o = 1'b0;
        else count_pin_o = 1'b0;
        repeat (3) @(negedge clk_i);
        trig_pin_o  = 1'b1;
        count_pin_o = 1'b1;
        repeat (3) @(negedge clk_i);
    endtask : pulse
    // trigger level steers direction in up/down mode
    task hold_trig(input logic lvl);
        @(negedge clk_i);
        trig_pin_o = lvl;
    endtask : hold_trig
endmodule : t2_far_model

// File: timer2_capture_reload_baudgen_tb_top.sv
// self-checking bench for the third timer
`timescale 1ns/1ns
module timer2_capture_reload_baudgen_tb_top;
    import t2_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        irq_en = 1'b0;
    t2_sfr_req_t req = '0;
    logic [7:0]  rdata;
    logic        irq;
    logic        cnt_pin;
    logic        trig_pin;
    t2_baud_t    baud;
    logic [7:0]  d;
    int          fail_count = 0;
    int          check_count = 0;

    always #20 clk = ~clk;

    // short prescaler keeps the timer scenarios brief
    t2_timer #(.MC_DIV(4)) dut (
        .CLK_SYS_I(clk), .RST_I(rst), .SFR_REQ_I(req), .SFR_RDATA_O(rdata),
        .COUNT_PIN_I(cnt_pin), .TRIGGER_PIN_I(trig_pin), .TIMER_IRQ_EN_I(irq_en),
        .IRQ_O(irq), .BAUD_O(baud));
    t2_far_model u_far (.clk_i(clk), .baud_i(baud), .count_pin_o(cnt_pin),
        .trig_pin_o(trig_pin));

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        req <= '0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(negedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        req <= '0;
        d = rdata;
    endtask : rd
    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task tally_and_finish;
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task t_reset;
        rd(8'hc8); check("control reset", d, 16'h0000);
        wr(8'hc9, 8'hff);
        rd(8'hc9); check("mode reserved", d, 16'h0003);
        rd(8'hc0); check("unmapped", d, 16'h0000);
        wr(8'hc9, 8'h00);
    endtask : t_reset
    task t_overflow;
        irq_en = 1'b1;
        wr(8'hcd, 8'hff);
        wr(8'hcc, 8'hfe);
        wr(8'hcb, 8'h12);
        wr(8'hca, 8'h34);
        idle(20);
        rd(8'hcc); check("stopped", d, 16'h00fe);
        wr(8'hc8, 8'h04);
        idle(20);
        rd(8'hc8); check("ovf flag", d, 16'h0084);
        check("irq ovf", irq, 1'b1);
        rd(8'hcd); check("reloaded", d, 16'h0012);
        wr(8'hc8, 8'h00);
        idle(3);
        check("irq clr", irq, 1'b0);
    endtask : t_overflow
    task t_capture;
        wr(8'hcd, 8'h00);
        wr(8'hcc, 8'h00);
        wr(8'hc8, 8'h0f);
        repeat (3) u_far.pulse(1'b0);
        u_far.pulse(1'b1);
        repeat (2) u_far.pulse(1'b0);
        idle(4);
        rd(8'hc8); check("ext flag", d, 16'h004f);
        wr(8'hc8, 8'h00);
        rd(8'hcc); check("pin count", d, 16'h0005);
        rd(8'hca); check("capt lo", d, 16'h0003);
        rd(8'hcb); check("capt hi", d, 16'h0000);
    endtask : t_capture
    task t_updown;
        wr(8'hc9, 8'h01);
        wr(8'hc8, 8'h40);
        idle(3);
        check("irq updown", irq, 1'b0);
        wr(8'hc9, 8'h00);
        idle(3);
        check("irq ext", irq, 1'b1);
        wr(8'hc8, 8'h00);
        // count down from 6 to the reload value 3, then wrap to all ones
        wr(8'hc9, 8'h01);
        wr(8'hcb, 8'h00);
        wr(8'hca, 8'h03);
        wr(8'hcd, 8'h00);
        wr(8'hcc, 8'h06);
        u_far.hold_trig(1'b0);
        wr(8'hc8, 8'h04);
        idle(20);
        rd(8'hc8); check("down ovf flag", d, 16'h0084);
        rd(8'hcd); check("down wrap", d, 16'h00ff);
        wr(8'hc8, 8'h08);
        u_far.hold_trig(1'b1);
        idle(2);
        u_far.pulse(1'b1);
        idle(4);
        rd(8'hc8); check("updown trig flag", d, 16'h0008);
        rd(8'hcd); check("updown no reload", d, 16'h00ff);
        wr(8'hc9, 8'h00);
        wr(8'hc8, 8'h00);
    endtask : t_updown
    // ticks in 40 cycles follow osc over 2 x (65536 - reload)
    task t_baud(input logic [7:0] lo, input int ticks);
        int t0;
        int r0;
        wr(8'hcb, 8'hff);
        wr(8'hca, lo);
        wr(8'hcd, 8'hff);
        wr(8'hcc, lo);
        wr(8'hc8, 8'h3c);
        idle(8);
        check("sel", {baud.rx_sel, baud.tx_sel}, 2'b11);
        t0 = u_far.tx_cnt;
        r0 = u_far.rx_cnt;
        idle(40);
        check("tx rate", 16'(u_far.tx_cnt - t0), 16'(ticks));
        check("rx rate", 16'(u_far.rx_cnt - r0), 16'(ticks));
        u_far.pulse(1'b1);
        idle(4);
        rd(8'hc8); check("baud flags", d, 16'h007c);
        wr(8'hc8, 8'h00);
    endtask : t_baud

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst <= 1'b0;
        t_reset();
        t_overflow();
        t_capture();
        t_updown();
        t_baud(8'hff, 20);
        t_baud(8'hfe, 10);
        tally_and_finish();
    end
    // run needs under a thousand cycles; ten thousand means a hang
    initial begin
        #400000;
        fail_count++;
        tally_and_finish();
    end
endmodule : timer2_capture_reload_baudgen_tb_top
